// ==== hdl/tpm_pcs_datapath.sv ====
// pcs mode datapath: polarity flip, mode configuration, fixed latency
`timescale 1ns/10ps
module tpm_pcs_datapath (
  input  wire logic                      i_clk,        // fabric clock
  input  wire logic                      i_rst_n,      // async reset low
  input  wire logic                      i_ce,         // clock enable
  input  wire tpm_pkg::tpm_mode_e        i_mode,       // functional mode
  input  wire tpm_pkg::tpm_align_e       i_align,      // aligner choice
  input  wire logic                      i_enc_en,     // 8b10b in detlat
  input  wire logic                      i_bser_en,    // byte serdes detlat
  input  wire logic [2:0]                i_bond,       // bonded channels
  input  wire logic                      i_tx_reg_en,  // tx fifo registered
  input  wire logic                      i_tx_flip,    // tx polarity flip pin
  input  wire logic [tpm_pkg::TPM_FAB_W-1:0] i_tx_data, // fabric tx word
  input  wire logic                      i_tx_valid,   // tx word valid
  output logic                           o_tx_ready,   // tx buffer room
  output logic [tpm_pkg::TPM_SYM_W-1:0]  o_ser_data,   // to serializer
  output logic                           o_ser_valid,  // serializer strobe
  input  wire logic                      i_ser_ready,  // serializer accepts
  input  wire logic [tpm_pkg::TPM_FAB_W-1:0] i_rx_data, // from pcs rx
  output logic [tpm_pkg::TPM_FAB_W-1:0]  o_rx_data,    // fabric rx word
  output logic [4:0]                     o_fab_width,  // fabric width bits
  output logic                           o_bser_on,    // byte serdes used
  output logic                           o_enc_on,     // 8b10b active
  output logic                           o_rmatch_on,  // rate match fifo on
  output logic                           o_order_on,   // byte ordering on
  output logic                           o_auto_sync,  // auto sync aligner
  output logic                           o_hip_on,     // hard core in path
  output logic                           o_cfg_err     // illegal combination
);
  import tpm_pkg::*;

  // ************************************************************
  // reset and pin synchronisers
  // ************************************************************
  logic rst_s1_reg;
  logic rst_n_reg;
  logic flip_s1_reg;
  logic flip_s2_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_reg <= TPM_RST_BIT;
      rst_n_reg  <= TPM_RST_BIT;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // flip pin may come from anywhere, so it is synchronised
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      flip_s1_reg <= TPM_RST_BIT;
      flip_s2_reg <= TPM_RST_BIT;
    end else if (i_ce) begin
      flip_s1_reg <= i_tx_flip;
      flip_s2_reg <= flip_s1_reg;
    end
  end

  // ************************************************************
  // mode decode
  // ************************************************************
  wire is_hip  = (i_mode == TPM_MODE_HARDIP);
  wire is_pipe = (i_mode == TPM_MODE_PIPE);
  wire is_dl   = (i_mode == TPM_MODE_DETLAT);

  // hard core drops byte serdes, pipe forces it, detlat picks
  wire bser_w = is_pipe || (is_dl && i_bser_en);
  wire enc_w  = is_hip || is_pipe || (is_dl && i_enc_en);
  wire rm_w   = is_pipe || is_hip;
  wire ord_w  = 1'b0;
  wire auto_w = !is_dl;
  wire hip_w  = is_hip;

  logic [4:0] width_w;
  assign width_w = is_hip  ? TPM_W_8 :
                   is_pipe ? TPM_W_16 :
                   (enc_w && bser_w)  ? TPM_W_16 :
                   (enc_w && !bser_w) ? TPM_W_8 :
                   (!enc_w && bser_w) ? TPM_W_20 : TPM_W_10;

  wire bond_ok_pipe = (i_bond == TPM_BOND_1) || (i_bond == TPM_BOND_2)
                   || (i_bond == TPM_BOND_4);
  wire bond_ok_dl   = (i_bond == TPM_BOND_1) || (i_bond == TPM_BOND_4);
  wire align_ok     = is_dl ? (i_align == TPM_ALIGN_MANUAL
                            || i_align == TPM_ALIGN_BITSLIP)
                            : (i_align == TPM_ALIGN_AUTO);
  wire err_w = (is_pipe && !bond_ok_pipe) || (is_dl && !bond_ok_dl)
            || !align_ok || (!is_hip && !is_pipe && !is_dl);

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_fab_width <= TPM_W_8;
      o_bser_on   <= TPM_RST_BIT;
      o_enc_on    <= TPM_RST_BIT;
      o_rmatch_on <= TPM_RST_BIT;
      o_order_on  <= TPM_RST_BIT;
      o_auto_sync <= TPM_RST_BIT;
      o_hip_on    <= TPM_RST_BIT;
      o_cfg_err   <= TPM_RST_BIT;
    end else if (i_ce) begin
      o_fab_width <= width_w;
      o_bser_on   <= bser_w;
      o_enc_on    <= enc_w;
      o_rmatch_on <= rm_w;
      o_order_on  <= ord_w;
      o_auto_sync <= auto_w;
      o_hip_on    <= hip_w;
      o_cfg_err   <= err_w;
    end
  end

  // ************************************************************
  // transmit path: buffer, serializer word split, polarity
  // ************************************************************
  logic [TPM_FAB_W-1:0] buf_data;
  logic                 buf_valid;
  logic                 buf_ready;

  tpm_skid_buf u_buf (
    .i_clk   (i_clk),
    .i_rst_n (rst_n_reg),
    .i_ce    (i_ce),
    .i_data  (i_tx_data),
    .i_valid (i_tx_valid),
    .o_ready (o_tx_ready),
    .o_data  (buf_data),
    .o_valid (buf_valid),
    .i_ready (buf_ready)
  );

  // byte serdes sends the low half then the high half of a word
  logic half_reg;
  logic flip_reg;
  logic [TPM_SYM_W-1:0] sym_w;
  wire  ser_free  = !o_ser_valid || i_ser_ready;
  wire  take_sym  = ser_free && buf_valid;
  wire  last_half = !bser_w || half_reg;
  assign buf_ready = take_sym && last_half;
  wire  word_start = take_sym && (!bser_w || !half_reg);

  assign sym_w = (bser_w && half_reg) ? buf_data[TPM_FAB_W-1:TPM_SYM_W]
                                      : buf_data[TPM_SYM_W-1:0];

  // flip sampled only when a new fabric word begins
  wire flip_now = word_start ? flip_s2_reg : flip_reg;

  // all ten symbol bits flip, coded or raw, so a swapped pair is undone
  logic [TPM_SYM_W-1:0] flip_mask;
  assign flip_mask = {TPM_SYM_W{flip_now}};
  logic [TPM_SYM_W-1:0] tx_word;
  assign tx_word = sym_w ^ flip_mask;

  // tx fifo: registered gives 1 stage, bypass gives no stage
  logic [TPM_SYM_W-1:0] tx_stage_reg;
  logic                 tx_stage_v_reg;

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      half_reg       <= TPM_RST_BIT;
      flip_reg       <= TPM_RST_BIT;
      tx_stage_reg   <= '0;
      tx_stage_v_reg <= TPM_RST_BIT;
      o_ser_data     <= '0;
      o_ser_valid    <= TPM_RST_BIT;
    end else if (i_ce) begin
      if (take_sym) half_reg <= bser_w && !half_reg;
      if (word_start) flip_reg <= flip_s2_reg;
      if (ser_free) begin
        tx_stage_reg   <= tx_word;
        tx_stage_v_reg <= take_sym;
        // registered mode is one fixed pipeline stage
        o_ser_data  <= (is_dl && i_tx_reg_en) ? tx_stage_reg : tx_word;
        o_ser_valid <= (is_dl && i_tx_reg_en) ? tx_stage_v_reg
                                              : take_sym;
      end
    end
  end

  // ************************************************************
  // receive path: fixed depth registered pipeline
  // ************************************************************
  logic [TPM_FAB_W-1:0] rx_pipe_reg [TPM_PIPE_MAX];
  logic [2:0]           rx_tap;
  // detlat always registered; fixed taps of 5 or 8 cycles
  assign rx_tap = bser_w ? 3'(TPM_RX_LAT_BS - 1)
                         : 3'(TPM_RX_LAT_NOBS - 1);

  genvar g;
  generate
    for (g = 0; g < TPM_PIPE_MAX; g++) begin : g_rx
      // stage 0 takes the input; index kept legal for stage 0
      wire [TPM_FAB_W-1:0] stage_in;
      assign stage_in = (g == 0) ? i_rx_data
                                 : rx_pipe_reg[(g == 0) ? 0 : g - 1];
      always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          rx_pipe_reg[g] <= '0;
        end else if (i_ce) begin
          rx_pipe_reg[g] <= stage_in;
        end
      end
    end
  endgenerate

  // pipe and hard core take two registers, stage 0 then the output, no fixed figure needed
  wire [TPM_FAB_W-1:0] rx_sel = is_dl ? rx_pipe_reg[rx_tap]
                                      : rx_pipe_reg[0];

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_rx_data <= '0;
    end else if (i_ce) begin
      o_rx_data <= rx_sel;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // consecutive enabled cycles, so long latency checks skip frozen spans
  logic [3:0] ce_run_reg;

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ce_run_reg <= {1'b0, TPM_RST_CNT};
    end else if (!i_ce) begin
      ce_run_reg <= {1'b0, TPM_RST_CNT};
    end else if (ce_run_reg != 4'hf) begin
      ce_run_reg <= ce_run_reg + 4'h1;
    end
  end

  sequence s_flip_change;
    i_ce && $changed(flip_s2_reg) && !word_start;
  endsequence

  sequence s_reg_take;
    i_ce && take_sym && is_dl && i_tx_reg_en;
  endsequence

  sequence s_reg_move;
    i_ce && ser_free && is_dl && i_tx_reg_en;
  endsequence

  // real words only: buffer entries hold nothing before the first push
  a_flip_inverts: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (i_ce && take_sym && !(is_dl && i_tx_reg_en))
    |=> (o_ser_data == $past(sym_w ^ {TPM_SYM_W{flip_now}})))
    else $error("serializer word not inverted as flip says");

  a_flip_boundary: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    s_flip_change |=> ($stable(flip_reg) || $past(word_start)))
    else $error("flip changed inside a word");

  a_hip_width: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (i_ce && is_hip) |=> (o_fab_width == TPM_W_8 && !o_bser_on))
    else $error("hard core width wrong");

  a_pipe_cfg: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (i_ce && is_pipe) |=> (o_fab_width == TPM_W_16 && o_bser_on
      && o_enc_on && o_rmatch_on && !o_order_on && o_auto_sync))
    else $error("pipe configuration wrong");

  a_dl_cfg: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (i_ce && is_dl) |=> (!o_rmatch_on && !o_order_on && !o_auto_sync))
    else $error("detlat disabled blocks active");

  a_dl_width: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (i_ce && is_dl && !i_enc_en && i_bser_en) |=> (o_fab_width == TPM_W_20))
    else $error("detlat width wrong");

  a_pipe_bypass: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (i_ce && is_pipe) |=> !o_hip_on)
    else $error("pipe mode kept hard core");

  a_rx_lat_bs: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (is_dl && i_bser_en && i_ce)[*7] |-> (o_rx_data == $past(i_rx_data, 6)))
    else $error("rx latency not fixed");

  a_rx_lat_nobs: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (ce_run_reg >= 4'h9 && $past(is_dl && !i_bser_en))
    |-> (o_rx_data == $past(i_rx_data, 9)))
    else $error("rx latency without byte serdes not fixed");

  a_tx_reg_lat: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    s_reg_take ##1 s_reg_move |=> (o_ser_valid
      && o_ser_data == $past(tx_word, 2)))
    else $error("registered tx stage not one fixed cycle");

  a_dl_w16: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (i_ce && is_dl && i_enc_en && i_bser_en) |=> (o_fab_width == TPM_W_16))
    else $error("detlat coded byte serdes width wrong");

  a_dl_w8: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (i_ce && is_dl && i_enc_en && !i_bser_en) |=> (o_fab_width == TPM_W_8))
    else $error("detlat coded width wrong");

  a_dl_w10: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (i_ce && is_dl && !i_enc_en && !i_bser_en) |=> (o_fab_width == TPM_W_10))
    else $error("detlat raw width wrong");

  a_dl_bond: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
    (i_ce && is_dl && i_bond == TPM_BOND_2) |=> o_cfg_err)
    else $error("detlat two channel bonding not flagged");

endmodule // tpm_pcs_datapath

// ==== hdl/tpm_pkg.sv ====
// package: mode, width and latency constants for the pcs mode datapath
package tpm_pkg;

  // functional modes of the channel
  typedef enum logic [1:0] {
    TPM_MODE_HARDIP,
    TPM_MODE_PIPE,
    TPM_MODE_DETLAT
  } tpm_mode_e;

  // word aligner operating choices
  typedef enum logic [1:0] {
    TPM_ALIGN_AUTO,
    TPM_ALIGN_MANUAL,
    TPM_ALIGN_BITSLIP
  } tpm_align_e;

  localparam int TPM_FAB_W          = 20;
  localparam int TPM_SYM_W          = 10;

  // fabric interface widths
  localparam logic [4:0] TPM_W_8    = 5'h08;
  localparam logic [4:0] TPM_W_10   = 5'h0a;
  localparam logic [4:0] TPM_W_16   = 5'h10;
  localparam logic [4:0] TPM_W_20   = 5'h14;

  // bonding counts
  localparam logic [2:0] TPM_BOND_1 = 3'h1;
  localparam logic [2:0] TPM_BOND_2 = 3'h2;
  localparam logic [2:0] TPM_BOND_4 = 3'h4;

  // rates in kbps and fabric clock in khz
  localparam int TPM_PIPE_RATE_KBPS = 2500000;
  localparam int TPM_PIPE_FCLK_KHZ  = 125000;
  localparam int TPM_HIP_FCLK_KHZ   = 250000;
  localparam int TPM_DL_MIN_KBPS    = 600000;
  localparam int TPM_DL_MAX_BS_KBPS = 3125000;
  localparam int TPM_DL_MAX_KBPS    = 1562500;
  localparam int TPM_DL_FCLK_KHZ    = 156250;
  localparam int TPM_CPRI_MIN_KBPS  = 614400;
  localparam int TPM_OBSAI_MIN_KBPS = 768000;
  localparam int TPM_LINK_MAX_KBPS  = 3072000;

  // fixed pipeline depths in fabric cycles (registered fifo mode)
  localparam int TPM_TX_LAT_BS      = 3;
  localparam int TPM_TX_LAT_NOBS    = 4;
  localparam int TPM_RX_LAT_BS      = 5;
  localparam int TPM_RX_LAT_NOBS    = 8;
  localparam int TPM_PIPE_MAX       = 8;

  // rtt accuracy, in ps
  localparam int TPM_RTT_ACC_PS     = 16276;

  // reset values
  localparam logic       TPM_RST_BIT = 1'b0;
  localparam logic [2:0] TPM_RST_CNT = 3'h0;

endpackage

// ==== hdl/tpm_skid_buf.sv ====
// two-entry valid/ready buffer in the transmit word path
`timescale 1ns/10ps
module tpm_skid_buf (
  input  wire logic                        i_clk,   // clock
  input  wire logic                        i_rst_n, // synced reset
  input  wire logic                        i_ce,    // clock enable
  input  wire logic [tpm_pkg::TPM_FAB_W-1:0] i_data, // word in
  input  wire logic                        i_valid, // word in valid
  output logic                             o_ready, // room available
  output logic [tpm_pkg::TPM_FAB_W-1:0]    o_data,  // word out
  output logic                             o_valid, // word out valid
  input  wire logic                        i_ready  // sink accepts
);
  import tpm_pkg::*;

  logic [TPM_FAB_W-1:0] mem_reg [2];
  logic                 wp_reg;
  logic                 rp_reg;
  logic [1:0]           cnt_reg;
  logic [1:0]           cnt_next;
  logic                 rdy_reg;
  wire                  push = i_valid && rdy_reg;
  wire                  pop  = i_ready && (cnt_reg != 2'h0);

  // head entry read straight out; ready kept in a flop of its own
  assign o_data   = mem_reg[rp_reg];
  assign o_valid  = (cnt_reg != 2'h0);
  assign o_ready  = rdy_reg;
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
      rdy_reg <= !TPM_RST_BIT;
    end else if (i_ce) begin
      if (push) wp_reg <= ~wp_reg;
      if (pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_next;
      rdy_reg <= (cnt_next != 2'h2);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && push) mem_reg[wp_reg] <= i_data;
  end

endmodule // tpm_skid_buf

// ==== verif/tpm_fab_src.sv ====
// fabric-side model: queued word source with valid/ready hold
`timescale 1ns/10ps
module tpm_fab_src (
  input  wire logic                          i_clk,   // fabric clock
  input  wire logic                          i_rst_n, // reset, low
  input  wire logic                          i_ready, // block has room
  output logic [tpm_pkg::TPM_FAB_W-1:0]      o_data,  // word to block
  output logic                               o_valid  // word valid
);
  import tpm_pkg::*;
  logic [TPM_FAB_W-1:0] q[$];
  // word held until taken; idle data toggles so stale words never match
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_data  <= 20'h00000;
    end else if (!o_valid || i_ready) begin
      if (q.size() > 0) begin
        o_valid <= 1'b1;
        o_data  <= q.pop_front();
      end else begin
        o_valid <= 1'b0;
        o_data  <= ~o_data;
      end
    end
  end
endmodule // tpm_fab_src

// ==== verif/tb.sv ====
// testbench for the pcs mode datapath
`timescale 1ns/10ps
module tb;
  import tpm_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  tpm_mode_e   mode = TPM_MODE_HARDIP;
  tpm_align_e  align = TPM_ALIGN_AUTO;
  logic        enc = 1'b0, bser = 1'b0, treg = 1'b0, flip = 1'b0;
  logic        ser_rdy = 1'b1;
  logic [2:0]  bond = TPM_BOND_1;
  logic [19:0] rx_in = 20'h00000, rx_out, src_d;
  logic [9:0]  ser_d;
  logic [4:0]  fab_w;
  logic        src_v, tx_rdy, ser_v, cfg_err;
  logic        bser_on, enc_on, rm_on, ord_on, auto_on, hip_on;
  int          err_count = 0, n_tests = 0, cyc = 0, acc_c = 0, out_c = 0;
  logic [9:0]  got_q[$];
  logic [19:0] w_hold;

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rx_in <= rx_in + 20'h00001;
    if (src_v && tx_rdy) acc_c <= cyc;
    if (ser_v && ser_rdy) begin
      if (got_q.size() == 0) out_c <= cyc;
      got_q.push_back(ser_d);
    end
  end

  tpm_pcs_datapath u_tpm_pcs_datapath (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_mode(mode),
    .i_align(align), .i_enc_en(enc), .i_bser_en(bser), .i_bond(bond),
    .i_tx_reg_en(treg), .i_tx_flip(flip), .i_tx_data(src_d),
    .i_tx_valid(src_v), .o_tx_ready(tx_rdy), .o_ser_data(ser_d),
    .o_ser_valid(ser_v), .i_ser_ready(ser_rdy), .i_rx_data(rx_in),
    .o_rx_data(rx_out), .o_fab_width(fab_w), .o_bser_on(bser_on),
    .o_enc_on(enc_on), .o_rmatch_on(rm_on), .o_order_on(ord_on),
    .o_auto_sync(auto_on), .o_hip_on(hip_on), .o_cfg_err(cfg_err));
  tpm_fab_src u_tpm_fab_src (.i_clk(clk), .i_rst_n(rst_n),
    .i_ready(tx_rdy), .o_data(src_d), .o_valid(src_v));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic setcfg(input tpm_mode_e m, input tpm_align_e a,
                        input logic e, input logic b, input logic [2:0] d);
    @(posedge clk);
    mode <= m;
    align <= a;
    enc <= e;
    bser <= b;
    bond <= d;
  endtask
  // exp/msk: width, bser, enc, rmatch, order, auto, hardip, err
  task automatic cfg_case(input tpm_mode_e m, input tpm_align_e a,
    input logic e, input logic b, input logic [2:0] d,
    input logic [11:0] exp, input logic [11:0] msk);
    setcfg(m, a, e, b, d);
    repeat (3) @(posedge clk);
    #1 chk({8'h00, {fab_w, bser_on, enc_on, rm_on, ord_on, auto_on,
            hip_on, cfg_err} & msk}, {8'h00, exp & msk});
  endtask
  task automatic rx_case(input tpm_mode_e m, input tpm_align_e a,
                         input logic b, input logic [19:0] lat);
    setcfg(m, a, 1'b1, b, TPM_BOND_1);
    repeat (12) @(posedge clk);
    repeat (4) begin
      #1 chk(rx_out, rx_in - lat);
      @(posedge clk);
    end
  endtask
  task automatic wait_sym(input int n);
    int k;
    k = 0;
    while (got_q.size() < n && k < 60) begin
      @(posedge clk);
      k++;
    end
    #1 chk(20'(got_q.size()), 20'(n));
  endtask
  task automatic tx_flip(input logic f, input logic r);
    int lat;
    setcfg(TPM_MODE_DETLAT, TPM_ALIGN_BITSLIP, 1'b0, 1'b0, TPM_BOND_1);
    flip <= f;
    treg <= r;
    repeat (8) @(posedge clk);
    got_q.delete();
    u_tpm_fab_src.q.push_back(20'h5a3c6);
    wait_sym(1);
    chk({10'h000, got_q[0]}, {10'h000, 10'h3c6 ^ {10{f}}});
    lat = out_c - acc_c;
    // bypass answers in 1..2 cycles, registered in 2..3
    chk({19'h0, lat >= 1 + r && lat <= 2 + r}, 20'h1);
  endtask
  // serializer stalls with words queued; flip toggles mid-stream
  task automatic tx_stall;
    logic [19:0] w;
    logic [9:0]  a, b;
    setcfg(TPM_MODE_DETLAT, TPM_ALIGN_MANUAL, 1'b0, 1'b1, TPM_BOND_4);
    ser_rdy <= 1'b0;
    flip <= 1'b0;
    treg <= 1'b0;
    repeat (6) @(posedge clk);
    got_q.delete();
    for (int i = 0; i < 8; i++)
      u_tpm_fab_src.q.push_back({10'h2a0 + 10'(i), 10'h0c0 + 10'(i)});
    repeat (14) @(posedge clk);
    #1 chk({19'h0, tx_rdy}, 20'h0);
    chk({9'h0, ser_v, ser_d}, {9'h0, 1'b1, 10'h0c0});
    @(posedge clk);
    flip <= 1'b1;
    repeat (5) @(posedge clk);
    ser_rdy <= 1'b1;
    repeat (3) @(posedge clk);
    flip <= 1'b0;
    wait_sym(16);
    chk({19'h0, tx_rdy}, 20'h1);
    for (int i = 0; i < 8; i++) begin
      w = {10'h2a0 + 10'(i), 10'h0c0 + 10'(i)};
      a = got_q[2*i] ^ w[9:0];
      b = got_q[2*i+1] ^ w[19:10];
      chk({a, b}, {a, a});
      chk({19'h0, a === 10'h000 || a === 10'h3ff}, 20'h1);
      if (i == 1 || i == 7)
        chk({10'h000, a}, {10'h000, i == 1 ? 10'h3ff : 10'h000});
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    #100us;
    err_count++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 chk({11'h0, fab_w, tx_rdy, ser_v, hip_on, cfg_err},
           {11'h0, TPM_W_8, 4'h8});
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    cfg_case(TPM_MODE_HARDIP, TPM_ALIGN_AUTO, 1'b1, 1'b1, TPM_BOND_1,
             {TPM_W_8, 7'h02}, 12'hfc3);
    for (int d = 1; d <= 4; d = d * 2)
      cfg_case(TPM_MODE_PIPE, TPM_ALIGN_AUTO, 1'b0, 1'b0, 3'(d),
               {TPM_W_16, 7'h74}, 12'hfff);
    for (int a = 1; a <= 2; a++)
      for (int e = 0; e < 2; e++)
        for (int b = 0; b < 2; b++)
          cfg_case(TPM_MODE_DETLAT, tpm_align_e'(a), e[0], b[0],
                   a == 1 ? TPM_BOND_1 : TPM_BOND_4,
                   {e ? (b ? TPM_W_16 : TPM_W_8) : (b ? TPM_W_20 : TPM_W_10),
                    b[0], e[0], 5'h00}, 12'hfff);
    cfg_case(TPM_MODE_DETLAT, TPM_ALIGN_MANUAL, 1'b1, 1'b1, TPM_BOND_2,
             12'h001, 12'h001);
    cfg_case(TPM_MODE_DETLAT, TPM_ALIGN_AUTO, 1'b1, 1'b1, TPM_BOND_1,
             12'h001, 12'h001);
    cfg_case(TPM_MODE_PIPE, TPM_ALIGN_MANUAL, 1'b1, 1'b1, TPM_BOND_1,
             12'h001, 12'h001);
    rx_case(TPM_MODE_DETLAT, TPM_ALIGN_MANUAL, 1'b1, 20'h6);
    rx_case(TPM_MODE_DETLAT, TPM_ALIGN_BITSLIP, 1'b0, 20'h9);
    rx_case(TPM_MODE_PIPE, TPM_ALIGN_AUTO, 1'b1, 20'h2);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    #1 w_hold = rx_out;
    repeat (3) @(posedge clk);
    #1 chk(rx_out, w_hold);
    @(posedge clk);
    ce <= 1'b1;
    for (int k = 0; k < 4; k++)
      tx_flip(k[0], k[1]);
    tx_stall();
    finish_test;
  end
endmodule // tb
